// File: rtl/sls_pkg.sv
// Package for the streaming link sink user port
package sls_pkg;

  localparam int LANES  = 4;
  localparam int DW     = 64 * LANES;
  localparam int SYNC_W = 8;
  localparam int ERR_W  = LANES + 5;

  // Error vector positions above the per-lane CRC bits
  localparam int ERR_ALIGN = LANES;
  localparam int ERR_ZERO  = LANES + 1;
  localparam int ERR_OVF   = LANES + 2;
  localparam int ERR_SEU_C = LANES + 3;
  localparam int ERR_SEU_U = LANES + 4;

  // Timing
  localparam int CLK_NS      = 8;
  localparam int RST_SEQ_NS  = 256;
  localparam int RST_SEQ_CYC = (RST_SEQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 6;
  localparam int BCNT_W      = 16;

  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STAT     = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_BURSTS   = 8'h10;

  // Control fields
  localparam int CTRL_ADV  = 0;
  localparam int CTRL_ECC  = 1;
  localparam int CTRL_CONT = 2;
  localparam int CTRL_INJ  = 3;
  localparam int CTRL_W    = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

  // Status fields
  localparam int STAT_LINK  = 0;
  localparam int STAT_RST   = 1;
  localparam int STAT_INBST = 2;

  localparam logic [ERR_W-1:0] MASK_RST = '0;

  typedef struct packed {
    logic [DW-1:0]     data;
    logic [SYNC_W-1:0] sync;
    logic              valid;
    logic              first;
    logic              last;
  } sls_beat_t;

  typedef struct packed {
    logic [LANES-1:0] crc;
    logic             align_loss;
    logic             fifo_ovf;
    logic             seu_corr;
    logic             seu_unc;
  } sls_rxerr_t;

  typedef enum logic [2:0] {
    RS_HOLD = 3'b001,
    RS_SEQ  = 3'b010,
    RS_RUN  = 3'b100
  } sls_rst_state_t;

endpackage

// File: rtl/sls_sink_port.sv
// Sink user port: payload delivery, error vector, reset sequence, APB registers
`timescale 1ns/1ps

// Summary of operation
// R1 - Link-up rises once receive init is done and the port is out of reset.
// R2 - Downstream treats payload as invalid whenever link-up is low.
// R3 - Payload output is 64 bits per lane.
// R4 - An 8-bit sync vector carries the sync value sent by the far transmitter.
// R5 - Sync at burst end counts unused words of the last cycle; zero for one lane.
// R6 - Valid output is high in cycles carrying valid payload.
// R7 - Burst-first marks the first payload word of a burst.
// R8 - In continuous operation burst-first is given only once, with the first data.
// R9 - Burst-last marks the last payload word of a burst.
// R10 - A received end marker closing continuous operation is passed on.
// R11 - Error vector is lanes plus five wide; bit above alignment is always low.
// R12 - Low error bits flag per-lane CRC-32 errors; bit at lane count flags alignment loss.
// R13 - Error bit at lanes plus two flags FIFO overflow; ignored in advanced clocking.
// R14 - Bits at lanes plus three and four flag SEU corrected and uncorrectable with ECC in standard clocking.
// R15 - A single-bit input from the user injects a CRC-32 error into the link.
// R16 - Interface reset output is high during core reset until the sequence finishes.
// R17 - User clock drives transfers in standard mode, interface clock in advanced mode.
// R18 - While interface reset is high, valid, markers, link-up and errors stay low.
module sls_sink_port
  import sls_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   core_reset,
  input  wire logic                   rx_init_done,
  input  wire sls_pkg::sls_beat_t     rx_beat,
  input  wire sls_pkg::sls_rxerr_t    rx_err,
  input  wire logic                   crc_inject_req,
  output logic      [sls_pkg::DW-1:0] sink_data,
  output logic      [7:0]             sink_sync,
  output logic                        sink_valid,
  output logic                        sink_burst_first,
  output logic                        sink_burst_last,
  output logic                        sink_link_up,
  output logic [sls_pkg::ERR_W-1:0]   sink_error,
  output logic                        sink_iface_reset,
  output logic                        sink_user_clk,
  output logic                        sink_iface_clk,
  output logic                        crc_inject_pulse,
  output logic                        irq
);
  import sls_pkg::*;

  logic [CTRL_W-1:0] ctrl_reg;
  logic [ERR_W-1:0]  irq_stat_reg;
  logic [ERR_W-1:0]  irq_mask_reg;
  logic [BCNT_W-1:0] bursts_reg;
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic [1:0]        crst_sync_reg;
  logic [1:0]        inj_sync_reg;
  logic              inj_d_reg;
  logic              inj_reg;
  sls_rst_state_t    rst_state_reg;
  sls_rst_state_t    rst_state_next;
  logic [CNT_W-1:0]  rst_cnt_reg;
  logic              iface_rst_reg;
  logic              rst_next;
  logic              link_up_reg;
  logic              seen_first_reg;
  logic              clk_div_reg;
  sls_beat_t         beat_reg;
  logic [ERR_W-1:0]  err_reg;
  logic [ERR_W-1:0]  err_now;
  logic              acc;
  logic              done;
  logic              adv;
  logic              cont;

  assign adv  = ctrl_reg[CTRL_ADV];
  assign cont = ctrl_reg[CTRL_CONT];
  assign acc  = psel & penable;
  // Access completes only on the cycle pready is seen high
  assign done = acc & pready_reg;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  function automatic logic [ERR_W-1:0] err_map(input sls_rxerr_t e,
                                               input logic adv_m,
                                               input logic ecc_m);
    err_map              = '0;
    err_map[LANES-1:0]   = e.crc;
    err_map[ERR_ALIGN]   = e.align_loss;
    err_map[ERR_ZERO]    = 1'b0;
    err_map[ERR_OVF]     = e.fifo_ovf & ~adv_m;
    err_map[ERR_SEU_C]   = e.seu_corr & ecc_m & ~adv_m;
    err_map[ERR_SEU_U]   = e.seu_unc & ecc_m & ~adv_m;
  endfunction

  // Core reset comes from a pin
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      crst_sync_reg <= 2'h3;
    else
      crst_sync_reg <= {crst_sync_reg[0], core_reset};
  end

  // R16 reset sequence
  always_comb
  begin
    rst_state_next = rst_state_reg;
    unique case (rst_state_reg)
      RS_HOLD:
        if (!crst_sync_reg[1])
          rst_state_next = RS_SEQ;
      RS_SEQ:
        if (crst_sync_reg[1])
          rst_state_next = RS_HOLD;
        else if (rst_cnt_reg == CNT_W'(RST_SEQ_CYC - 1))
          rst_state_next = RS_RUN;
      RS_RUN:
        if (crst_sync_reg[1])
          rst_state_next = RS_HOLD;
      default:
        rst_state_next = RS_HOLD;
    endcase
  end

  assign rst_next = (rst_state_next != RS_RUN);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_state_reg <= RS_HOLD;
      rst_cnt_reg   <= '0;
      iface_rst_reg <= 1'b1;
    end
    else
    begin
      rst_state_reg <= rst_state_next;
      rst_cnt_reg   <= (rst_state_reg == RS_SEQ) ? rst_cnt_reg + 1'b1 : '0;
      iface_rst_reg <= rst_next;
    end
  end

  // R1 R18 link-up
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      link_up_reg <= 1'b0;
    else
      link_up_reg <= ~rst_next & rx_init_done;
  end

  // R8 continuous stream opened
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      seen_first_reg <= 1'b0;
    else if (rst_next || !cont)
      seen_first_reg <= 1'b0;
    else if (rx_beat.valid && rx_beat.last)
      seen_first_reg <= 1'b0;
    else if (rx_beat.valid && rx_beat.first)
      seen_first_reg <= 1'b1;
  end

  // R3 R4 R5 R6 R18 payload, sync, qualifier
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      beat_reg <= '0;
    else if (rst_next)
      beat_reg <= '0;
    else
    begin
      beat_reg.data  <= rx_beat.data;
      beat_reg.sync  <= rx_beat.sync;
      beat_reg.valid <= rx_beat.valid;
      // R7 R8 first marker, once per continuous stream
      beat_reg.first <= rx_beat.valid & rx_beat.first & ~(cont & seen_first_reg);
      // R9 R10 last marker passed in both modes
      beat_reg.last  <= rx_beat.valid & rx_beat.last;
    end
  end

  // R11 R12 R13 R14 R18 error vector
  assign err_now = rst_next ? '0 : err_map(rx_err, adv, ctrl_reg[CTRL_ECC]);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      err_reg <= '0;
    else
      err_reg <= err_now;
  end

  // Read clears only bits returned; events after the capture survive
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      irq_stat_reg <= '0;
    else if (done && !pwrite && addr_is(paddr, OFS_IRQ_STAT))
      irq_stat_reg <= (irq_stat_reg & ~prdata_reg[ERR_W-1:0]) | err_now;
    else
      irq_stat_reg <= irq_stat_reg | err_now;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_reg & irq_mask_reg);
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      bursts_reg <= '0;
    else if (beat_reg.first)
      bursts_reg <= bursts_reg + 1'b1;
  end

  // R15 injection from pin or register, one pulse per request
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      inj_sync_reg <= 2'h0;
      inj_d_reg    <= 1'b0;
      inj_reg      <= 1'b0;
    end
    else
    begin
      inj_sync_reg <= {inj_sync_reg[0], crc_inject_req};
      inj_d_reg    <= inj_sync_reg[1];
      inj_reg      <= (inj_sync_reg[1] & ~inj_d_reg)
                    | (done & pwrite & addr_is(paddr, OFS_CTRL) & pwdata[CTRL_INJ]);
    end
  end

  // R17 transfer clock on the output of the selected mode
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_div_reg    <= 1'b0;
      sink_user_clk  <= 1'b0;
      sink_iface_clk <= 1'b0;
    end
    else
    begin
      clk_div_reg    <= ~clk_div_reg;
      sink_user_clk  <= ~adv & ~clk_div_reg;
      sink_iface_clk <= adv & ~clk_div_reg;
    end
  end

  // APB: two-cycle access, answer registered
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready_reg  <= 1'b0;
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end
    else if (acc && !pready_reg)
    begin
      pready_reg  <= 1'b1;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
      unique case (1'b1)
        addr_is(paddr, OFS_CTRL):
          prdata_reg[CTRL_W-1:0] <= ctrl_reg;
        addr_is(paddr, OFS_STAT):
          prdata_reg[2:0] <= {seen_first_reg, iface_rst_reg, link_up_reg};
        addr_is(paddr, OFS_IRQ_STAT):
          prdata_reg[ERR_W-1:0] <= irq_stat_reg;
        addr_is(paddr, OFS_IRQ_MASK):
          prdata_reg[ERR_W-1:0] <= irq_mask_reg;
        addr_is(paddr, OFS_BURSTS):
          prdata_reg[BCNT_W-1:0] <= bursts_reg;
        default:
          pslverr_reg <= 1'b1;
      endcase
    end
    else
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_reg     <= CTRL_RST;
      irq_mask_reg <= MASK_RST;
    end
    else if (done && pwrite)
    begin
      if (addr_is(paddr, OFS_CTRL))
        ctrl_reg <= pwdata[CTRL_W-1:0];
      if (addr_is(paddr, OFS_IRQ_MASK))
        irq_mask_reg <= pwdata[ERR_W-1:0];
    end
  end

  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign sink_data        = beat_reg.data;
  assign sink_sync        = beat_reg.sync;
  assign sink_valid       = beat_reg.valid;
  assign sink_burst_first = beat_reg.first;
  assign sink_burst_last  = beat_reg.last;
  assign sink_link_up     = link_up_reg;
  assign sink_error       = err_reg;
  assign sink_iface_reset = iface_rst_reg;
  assign crc_inject_pulse = inj_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_seq_done;
    !crst_sync_reg[1] && rst_state_reg == RS_SEQ
      && rst_cnt_reg == CNT_W'(RST_SEQ_CYC - 1);
  endsequence

  sequence s_inj_edge;
    inj_sync_reg[1] && !inj_d_reg;
  endsequence

  a_reset_hold: assert property ( // R16
    crst_sync_reg[1] |=> sink_iface_reset)
    else $error("interface reset low during core reset");
  a_reset_release: assert property ( // R16
    $fell(sink_iface_reset) |-> $past(rst_state_reg == RS_SEQ
      && rst_cnt_reg == CNT_W'(RST_SEQ_CYC - 1)))
    else $error("interface reset released early");
  a_reset_done: assert property ( // R16
    s_seq_done |=> $fell(sink_iface_reset))
    else $error("interface reset not released");
  a_linkup_cause: assert property ( // R1
    $rose(sink_link_up) |-> $past(rx_init_done) && !sink_iface_reset)
    else $error("link-up without init");
  a_data_pass: assert property ( // R3
    !rst_next && rx_beat.valid |=> sink_valid && sink_data == $past(rx_beat.data)
      && sink_sync == $past(rx_beat.sync))
    else $error("payload not passed");
  a_first_once: assert property ( // R8
    cont && sink_burst_first && !sink_burst_last ##1 (cont && !sink_burst_last)[*1]
      |-> !sink_burst_first)
    else $error("second first marker in continuous stream");
  a_last_pass: assert property ( // R9
    !rst_next && rx_beat.valid && rx_beat.last |=> sink_burst_last)
    else $error("last marker lost");
  a_err_zero: assert property ( // R11
    !sink_error[ERR_ZERO])
    else $error("unused error bit set");
  a_ovf_adv: assert property ( // R13
    adv && $stable(adv) |=> !sink_error[ERR_OVF])
    else $error("overflow flagged in advanced clocking");
  a_seu_noecc: assert property ( // R14
    !ctrl_reg[CTRL_ECC] && $stable(ctrl_reg) |=> !sink_error[ERR_SEU_C]
      && !sink_error[ERR_SEU_U])
    else $error("SEU flagged without ECC");
  a_quiet_reset: assert property ( // R18
    sink_iface_reset |-> !sink_valid && !sink_burst_first && !sink_burst_last
      && !sink_link_up && sink_error == '0)
    else $error("activity during interface reset");
  a_inject_pulse: assert property ( // R15
    s_inj_edge |=> crc_inject_pulse ##1 (!crc_inject_pulse || $past(done)))
    else $error("inject pulse wrong");

endmodule

// File: dv/sls_user_sink.sv
// Downstream user logic model that consumes the sink stream
`timescale 1ns/1ps
module sls_user_sink
  import sls_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        link_up,
  input  wire logic        valid,
  input  wire logic        last,
  input  wire logic [7:0]  sync,
  output logic      [15:0] beat_cnt,
  output logic      [15:0] last_cnt,
  output logic      [7:0]  last_sync
);
  // gate on link-up
  // Valid alone is not trusted: words seen with the link down are dropped
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      beat_cnt <= '0;
    else if (link_up && valid)
      beat_cnt <= beat_cnt + 16'h1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      last_cnt  <= '0;
      last_sync <= '0;
    end
    else if (link_up && valid && last)
    begin
      last_cnt  <= last_cnt + 16'h1;
      last_sync <= sync;
    end
  end
endmodule

// File: dv/sls_sink_port_tb_top.sv
// Testbench for the streaming link sink user port
`timescale 1ns/1ps
module sls_sink_port_tb_top;
  import sls_pkg::*;
  // Flags are valid, first in, first expected, last
  typedef struct packed {
    logic [2:0] ctrl;
    logic [3:0] fl;
    logic [7:0] sync;
    logic [7:0] err;
    logic [8:0] xe;
  } sls_row_t;
  sls_row_t rows [11] = '{
    '{3'h0, 4'hE, 8'h03, 8'h00, 9'h000}, '{3'h0, 4'h8, 8'h00, 8'hA0, 9'h00A},
    '{3'h0, 4'h0, 8'h00, 8'h08, 9'h010}, '{3'h0, 4'h9, 8'h02, 8'h04, 9'h040},
    '{3'h0, 4'hF, 8'h00, 8'h03, 9'h000}, '{3'h2, 4'h8, 8'h00, 8'h07, 9'h1C0},
    '{3'h3, 4'h8, 8'h00, 8'h17, 9'h001}, '{3'h4, 4'hE, 8'h00, 8'h00, 9'h000},
    '{3'h4, 4'hC, 8'h00, 8'h00, 9'h000}, '{3'h4, 4'h9, 8'h01, 8'h00, 9'h000},
    '{3'h4, 4'hE, 8'h00, 8'h00, 9'h000}};
  logic             mclk = 1'b0;
  logic             reset_n = 1'b0;
  logic [7:0]       paddr = '0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [31:0]      pwdata = '0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             core_reset = 1'b1;
  logic             rx_init_done = 1'b0;
  sls_beat_t        rx_beat = '0;
  sls_rxerr_t       rx_err = '0;
  logic             crc_inject_req = 1'b0;
  logic [DW-1:0]    sink_data;
  logic [7:0]       sink_sync;
  logic             sink_valid;
  logic             sink_burst_first;
  logic             sink_burst_last;
  logic             sink_link_up;
  logic [ERR_W-1:0] sink_error;
  logic             sink_iface_reset;
  logic             sink_user_clk;
  logic             sink_iface_clk;
  logic             crc_inject_pulse;
  logic             irq;
  logic [15:0]      beat_cnt;
  logic [15:0]      last_cnt;
  logic [7:0]       last_sync;
  logic [31:0]      q;
  logic             e;
  logic             seen;
  logic [8:0]       acc = '0;
  logic [2:0]       mode = '0;
  int               err_count = 0;
  int               checks = 0;
  int               nb = 0;
  int               nf = 0;

  always #4 mclk = ~mclk;

  sls_sink_port DUT (.mclk(mclk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_reset(core_reset), .rx_init_done(rx_init_done),
    .rx_beat(rx_beat), .rx_err(rx_err), .crc_inject_req(crc_inject_req),
    .sink_data(sink_data), .sink_sync(sink_sync), .sink_valid(sink_valid),
    .sink_burst_first(sink_burst_first), .sink_burst_last(sink_burst_last),
    .sink_link_up(sink_link_up), .sink_error(sink_error),
    .sink_iface_reset(sink_iface_reset), .sink_user_clk(sink_user_clk),
    .sink_iface_clk(sink_iface_clk), .crc_inject_pulse(crc_inject_pulse), .irq(irq));

  sls_user_sink PART (.clk(mclk), .reset_n(reset_n), .link_up(sink_link_up),
    .valid(sink_valid), .last(sink_burst_last), .sync(sink_sync), .beat_cnt(beat_cnt),
    .last_cnt(last_cnt), .last_sync(last_sync));

  task automatic chk_v(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic chk_d(input logic [DW-1:0] x, input logic [DW-1:0] g);
    checks++;
    if (g !== x)
    begin
      err_count++;
      $display("MISMATCH sink_data expected %h seen %h", x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge mclk);
    end
    if (n >= 20)
      err_count++;
    q       = prdata;
    e       = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Long sequence; bounded so a stuck reset cannot hang the run
  task automatic wait_up();
    int n;
    n = 0;
    while (sink_iface_reset !== 1'b0 && n < 100)
    begin
      n++;
      @(posedge mclk);
      #1;
    end
    chk_v("iface_reset_release", 0, sink_iface_reset);
  endtask

  task automatic send(input sls_row_t r, input int i);
    @(posedge mclk);
    rx_beat <= '{data: {LANES{64'hC0DE_0000_0000_0000}} | DW'(i + 1), sync: r.sync,
                 valid: r.fl[3], first: r.fl[2], last: r.fl[0]};
    rx_err  <= sls_rxerr_t'(r.err);
    @(posedge mclk);
    rx_beat <= '0;
    rx_err  <= '0;
    #1;
  endtask

  task automatic stop_test();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    stop_test();
  end

  initial
  begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk_v("iface_reset", 1, sink_iface_reset);
    chk_v("valid", 0, sink_valid);
    repeat (6) @(posedge mclk);
    #1;
    chk_v("iface_reset", 1, sink_iface_reset);
    @(posedge mclk);
    core_reset <= 1'b0;
    wait_up();
    chk_v("link_up", 0, sink_link_up);
    @(posedge mclk);
    rx_init_done <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    chk_v("link_up", 1, sink_link_up);
    $display("test reset done");
    for (int i = 0; i < 11; i++)
    begin
      if (rows[i].ctrl != mode)
        apb(1'b1, OFS_CTRL, 32'(rows[i].ctrl));
      mode = rows[i].ctrl;
      send(rows[i], i);
      chk_v("valid", rows[i].fl[3], sink_valid);
      chk_v("first", rows[i].fl[1], sink_burst_first);
      chk_v("last", rows[i].fl[0], sink_burst_last);
      chk_v("sync", rows[i].sync, sink_sync);
      chk_v("error", rows[i].xe, sink_error);
      if (rows[i].fl[3])
        chk_d({LANES{64'hC0DE_0000_0000_0000}} | DW'(i + 1), sink_data);
      acc = acc | rows[i].xe;
      nb  = nb + rows[i].fl[3];
      nf  = nf + rows[i].fl[1];
    end
    // Partner counts one edge after the outputs show the beat
    @(posedge mclk);
    #1;
    chk_v("partner_beats", nb, beat_cnt);
    chk_v("partner_lasts", 3, last_cnt);
    chk_v("partner_sync", rows[9].sync, last_sync);
    $display("test table done");
    chk_v("irq_masked", 0, irq);
    apb(1'b1, OFS_IRQ_MASK, 32'h1FF);
    repeat (3) @(posedge mclk);
    #1;
    chk_v("irq", 1, irq);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk_v("irq_stat", 32'(acc), q);
    repeat (3) @(posedge mclk);
    #1;
    chk_v("irq_clear", 0, irq);
    apb(1'b0, 8'h40, 32'h0);
    chk_v("slverr", 1, e);
    apb(1'b0, OFS_BURSTS, 32'h0);
    chk_v("bursts", nf, q);
    $display("test irq done");
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, OFS_CTRL, 32'(m));
      repeat (2) @(posedge mclk);
      #1;
      seen = m ? sink_iface_clk : sink_user_clk;
      @(posedge mclk);
      #1;
      chk_v("clk_toggle", !seen, m ? sink_iface_clk : sink_user_clk);
      chk_v("clk_idle", 0, m ? sink_user_clk : sink_iface_clk);
    end
    $display("test clocks done");
    @(posedge mclk);
    crc_inject_req <= 1'b1;
    seen = 1'b0;
    repeat (8)
    begin
      @(posedge mclk);
      #1;
      seen = seen | crc_inject_pulse;
    end
    chk_v("inject_pin", 1, seen);
    crc_inject_req <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h8);
    // Pulse stands only in the cycle after the completing edge
    #1;
    chk_v("inject_reg", 1, crc_inject_pulse);
    $display("test inject done");
    @(posedge mclk);
    core_reset <= 1'b1;
    repeat (4) @(posedge mclk);
    send(rows[1], 1);
    chk_v("iface_reset", 1, sink_iface_reset);
    chk_v("valid", 0, sink_valid);
    chk_v("first", 0, sink_burst_first);
    chk_v("error", 0, sink_error);
    chk_v("link_up", 0, sink_link_up);
    @(posedge mclk);
    core_reset <= 1'b0;
    wait_up();
    chk_v("link_up", 1, sink_link_up);
    $display("test core reset done");
    @(posedge mclk);
    rx_init_done <= 1'b0;
    send(rows[0], 0);
    chk_v("link_down", 0, sink_link_up);
    chk_v("valid", 1, sink_valid);
    @(posedge mclk);
    #1;
    chk_v("partner_drop", nb, beat_cnt);
    $display("test link down done");
    stop_test();
  end
endmodule
